// ### hw/amcc_map.vh
`ifndef AMCC_MAP_VH
`define AMCC_MAP_VH
// ==========================================================
// timing
`define AMCC_CLK_MHZ        20
`define AMCC_CONV_TIME_US   40
`define AMCC_CONV_CYCLES    (`AMCC_CONV_TIME_US * `AMCC_CLK_MHZ)
`define AMCC_SAR_BITS       8
// internal half period: 8 bits plus one sample period fit in the conversion time
`define AMCC_PHASE_CYCLES   (`AMCC_CONV_CYCLES / ((`AMCC_SAR_BITS + 1) * 2))
// ==========================================================
// config fields and reset values
`define AMCC_CFG_W          5
`define AMCC_CFG_SE_BIT     3
`define AMCC_CFG_PD_BIT     4
`define AMCC_CFG_RST        5'h00
`define AMCC_RESULT_RST     8'h00
`define AMCC_GND_SEL        4'h8
`endif

// ### hw/amcc_mux_decode.v
`timescale 1ns/1ps
`include "amcc_map.vh"
// ==========================================================
// input pairing decode
module amcc_mux_decode
(
  // configuration
  input  wire [4:0] cfg,
  // selected inputs: 0..7 analog inputs, 8 analog ground
  output reg  [3:0] pos_sel,
  output reg  [3:0] neg_sel
);

  always @*
  begin
    if (!cfg[`AMCC_CFG_SE_BIT])
    begin
      pos_sel = {1'b0, cfg[2:1], cfg[0]};
      neg_sel = {1'b0, cfg[2:1], ~cfg[0]};
    end
    else if (!cfg[`AMCC_CFG_PD_BIT])
    begin
      pos_sel = {1'b0, cfg[2:0]};
      neg_sel = `AMCC_GND_SEL;
    end
    else
    begin
      pos_sel = {1'b0, cfg[2:0]};
      neg_sel = 4'h7;
    end
  end

endmodule // amcc_mux_decode

// ### hw/amcc_ctrl.v
`timescale 1ns/1ps
`include "amcc_map.vh"
// ==========================================================
// converter control: bus strobes, config latch, sar sequencing
module amcc_ctrl
(
  // clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // host bus pins
  input  wire       cs_n,
  input  wire       wr_n,
  input  wire       rd_n,
  input  wire [7:0] result_lines_i,
  output reg  [7:0] result_lines_o,
  output reg  [7:0] result_lines_oe,
  output reg        done_flag_n,
  // analog front end
  output reg  [3:0] pos_sel_r,
  output reg  [3:0] neg_sel_r,
  output reg        sample_pos_r,
  output reg        sample_neg_r,
  output reg  [7:0] dac_code_r,
  output reg        cmp_strobe_r,
  input  wire       cmp_above,
  output reg        busy_r
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SPOS = 2'd1;
  localparam ST_SNEG = 2'd2;
  localparam ST_BIT  = 2'd3;
  // full-width count first, then cut to the counter width on purpose
  localparam [31:0] PHASE_FULL = `AMCC_PHASE_CYCLES - 1;
  localparam [15:0] PHASE_MAX  = PHASE_FULL[15:0];

  // ==========================================================
  // pin synchronisers, two flops each
  reg  [2:0] s1_r;
  reg  [2:0] s2_r;
  reg  [4:0] d1_r;
  reg  [4:0] d2_r;
  reg        cmp1_r;
  reg        cmp2_r;
  reg        wr_prev_r;
  reg        rd_acc_prev_r;
  reg        rd_seen_r;
  reg  [4:0] cfg_r;
  reg  [4:0] cfg_cap_r;
  reg  [7:0] result_r;
  reg  [1:0] state_r;
  reg  [15:0] ph_cnt_r;
  reg        half_r;
  reg  [2:0] bit_r;

  wire cs_s   = s2_r[0];
  wire wr_s   = s2_r[1];
  wire rd_s   = s2_r[2];
  wire wr_fall = wr_prev_r & ~wr_s & ~cs_s;
  wire wr_rise = ~wr_prev_r & wr_s & ~cs_s;
  wire rd_acc  = ~cs_s & ~rd_s;
  wire rd_end  = rd_acc_prev_r & ~rd_acc;
  wire [3:0] pos_dec;
  wire [3:0] neg_dec;
  // only a write with the read strobe high brings in new config; a read restarts on the stored one
  wire [4:0] cfg_use = (wr_rise & ~rd_seen_r) ? cfg_cap_r : cfg_r;
  wire start = (wr_rise) | rd_end;
  wire ph_end = (ph_cnt_r == PHASE_MAX);
  wire conv_end = (state_r == ST_BIT) & ph_end & half_r & (bit_r == 3'd0);

  amcc_mux_decode u_dec
  (
    .cfg     (cfg_use),
    .pos_sel (pos_dec),
    .neg_sel (neg_dec)
  );

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      d1_r <= 5'h00;
      d2_r <= 5'h00;
      cmp1_r <= 1'b0;
      cmp2_r <= 1'b0;
    end
    else
    begin
      s1_r <= {rd_n, wr_n, cs_n};
      s2_r <= s1_r;
      d1_r <= result_lines_i[4:0];
      d2_r <= d1_r;
      cmp1_r <= cmp_above;
      cmp2_r <= cmp1_r;
    end
  end

  // ==========================================================
  // bus side: strobe history and config latch
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_prev_r <= 1'b1;
      rd_acc_prev_r <= 1'b0;
      rd_seen_r <= 1'b0;
      cfg_r <= `AMCC_CFG_RST;
      cfg_cap_r <= `AMCC_CFG_RST;
    end
    else
    begin
      wr_prev_r <= wr_s;
      rd_acc_prev_r <= rd_acc;
      if (wr_fall)
        rd_seen_r <= 1'b0;
      else if (~wr_s & ~rd_s)
        rd_seen_r <= 1'b1;
      if (~wr_s & ~cs_s & rd_s)
        cfg_cap_r <= d2_r;
      if (wr_rise)
        cfg_r <= cfg_use;
    end
  end

  // ==========================================================
  // done flag and output latch
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      result_r <= `AMCC_RESULT_RST;
      done_flag_n <= 1'b1;
    end
    else
    begin
      // conversion end sets flag low; a write fall or a read access in the same cycle wins, as the strobes demand it high
      if (wr_fall | rd_acc)
        done_flag_n <= 1'b1;
      else if (conv_end)
        done_flag_n <= 1'b0;
      if (conv_end)
        result_r <= cmp2_r ? dac_code_r : (dac_code_r & ~8'h01);
    end
  end

  // ==========================================================
  // read drive: lines released whenever select or read strobe is high
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      result_lines_o <= 8'h00;
      result_lines_oe <= 8'h00;
    end
    else
    begin
      result_lines_o <= result_r;
      result_lines_oe <= rd_acc ? 8'hFF : 8'h00;
    end
  end

  // ==========================================================
  // sar sequencer; restart on any new start, even mid-conversion
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      ph_cnt_r <= 16'h0000;
      half_r <= 1'b0;
      bit_r <= 3'd7;
      pos_sel_r <= 4'h0;
      neg_sel_r <= 4'h1;
      sample_pos_r <= 1'b0;
      sample_neg_r <= 1'b0;
      dac_code_r <= 8'h00;
      cmp_strobe_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      cmp_strobe_r <= 1'b0;
      sample_pos_r <= 1'b0;
      sample_neg_r <= 1'b0;
      if (start)
      begin
        state_r <= ST_SPOS;
        ph_cnt_r <= 16'h0000;
        half_r <= 1'b0;
        bit_r <= 3'd7;
        pos_sel_r <= pos_dec;
        neg_sel_r <= neg_dec;
        dac_code_r <= 8'h80;
        busy_r <= 1'b1;
        sample_pos_r <= 1'b1;
      end
      else if (state_r != ST_IDLE)
      begin
        ph_cnt_r <= ph_end ? 16'h0000 : ph_cnt_r + 16'h0001;
        if (ph_end)
          half_r <= ~half_r;
        case (state_r)
          ST_SPOS:
            if (ph_end)
            begin
              state_r <= ST_SNEG;
              sample_neg_r <= 1'b1;
            end
          ST_SNEG:
            if (ph_end)
              state_r <= ST_BIT;
          ST_BIT:
            if (ph_end && half_r)
            begin
              // decision at period end, away from switching edges
              cmp_strobe_r <= 1'b1;
              if (bit_r == 3'd0)
              begin
                state_r <= ST_IDLE;
                busy_r <= 1'b0;
              end
              else
              begin
                // keep or drop trial bit; saturates to FF or 00 naturally
                dac_code_r <= (cmp2_r ? dac_code_r : (dac_code_r & ~(8'h01 << bit_r)))
                              | (8'h01 << (bit_r - 3'd1));
                bit_r <= bit_r - 3'd1;
              end
            end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // amcc_ctrl

// ### sim/amcc_ctrl_properties.sv
`timescale 1ns/1ps
// ==========
// bus and sequencing properties
module amcc_ctrl_chk
(
  // watched ports
  input wire       core_clk,
  input wire       reset,
  input wire       cs_n,
  input wire       wr_n,
  input wire       rd_n,
  input wire [7:0] result_lines_oe,
  input wire       done_flag_n,
  input wire       sample_pos_r,
  input wire       sample_neg_r,
  input wire       cmp_strobe_r,
  input wire       busy_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // one sample phase of the sequencer is 44 core clocks: half an internal period
  property p_lag; sample_neg_r |-> $past(sample_pos_r, 44); endproperty
  a_lag: assert property (p_lag) else $error("neg sample lag");
  property p_wrf; $fell(wr_n) && !cs_n |-> ##[1:4] done_flag_n; endproperty
  a_wrf: assert property (p_wrf) else $error("done after wr fall");
  property p_rdd; (!cs_n && !rd_n) [*5] |-> done_flag_n && result_lines_oe == 8'hFF; endproperty
  a_rdd: assert property (p_rdd) else $error("read drive");
  property p_oe; (cs_n || rd_n) [*5] |-> result_lines_oe == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("lines not released");
  // the last decision strobe leaves in the same cycle as busy drops
  property p_cmp; cmp_strobe_r |-> $past(busy_r); endproperty
  a_cmp: assert property (p_cmp) else $error("strobe when idle");
  property p_end; $fell(busy_r) && cs_n |-> ##[0:2] !done_flag_n; endproperty
  a_end: assert property (p_end) else $error("done not low");
  property p_wst; $rose(wr_n) && !cs_n && rd_n |-> ##[1:6] sample_pos_r; endproperty
  a_wst: assert property (p_wst) else $error("write start");
  property p_rst; $rose(rd_n) && !cs_n |-> ##[1:6] sample_pos_r; endproperty
  a_rst: assert property (p_rst) else $error("read start");
endmodule // amcc_ctrl_chk
bind amcc_ctrl amcc_ctrl_chk i_amcc_ctrl_chk (.core_clk, .reset, .cs_n, .wr_n, .rd_n, .result_lines_oe,
  .done_flag_n, .sample_pos_r, .sample_neg_r, .cmp_strobe_r, .busy_r);

// ### sim/amcc_afe_model.sv
`timescale 1ns/1ps
// ==========
// analog front end: holds both inputs, compares with trial code
module amcc_afe_model
(
  // converter side
  input  wire        core_clk,
  input  wire [71:0] levels,
  input  wire [3:0]  pos_sel_r,
  input  wire [3:0]  neg_sel_r,
  input  wire        sample_pos_r,
  input  wire        sample_neg_r,
  input  wire [7:0]  dac_code_r,
  output wire        cmp_above
);
  reg [7:0] hp_r;
  reg [7:0] hn_r;
  always @(posedge core_clk)
  begin
    if (sample_pos_r)
      hp_r <= levels[pos_sel_r*8 +: 8];
    if (sample_neg_r)
      hn_r <= levels[neg_sel_r*8 +: 8];
  end
  // input sits half a step above its code, so > and >= trials agree
  assign cmp_above = {2'h0, hp_r, 1'h1} > {2'h0, hn_r, 1'h0} + {2'h0, dac_code_r, 1'h0};
endmodule // amcc_afe_model

// ### sim/amcc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, a); end end
module amcc_ctrl_tb;
  reg         core_clk = 0, reset = 1, cs_n = 1, wr_n = 1, rd_n = 1, oe_d = 0;
  reg  [7:0]  d = 8'h00, ev;
  reg  [71:0] lv = 72'h0;
  reg  [31:0] sd = 32'hBF26;
  reg  [7:0]  q[$];
  wire [7:0]  result_lines_o, result_lines_oe, dac_code_r;
  wire [3:0]  pos_sel_r, neg_sel_r;
  wire        done_flag_n, sample_pos_r, sample_neg_r, cmp_above;
  integer     num_errors = 0, n_compared = 0, i, k;
  initial forever #25 core_clk = ~core_clk;
  amcc_ctrl i_amcc_ctrl (.core_clk, .reset, .cs_n, .wr_n, .rd_n, .result_lines_i(d), .result_lines_o,
    .result_lines_oe, .done_flag_n, .pos_sel_r, .neg_sel_r, .sample_pos_r, .sample_neg_r, .dac_code_r,
    .cmp_strobe_r(), .cmp_above, .busy_r());
  amcc_afe_model i_amcc_afe_model (.core_clk, .levels(lv), .pos_sel_r, .neg_sel_r, .sample_pos_r,
    .sample_neg_r, .dac_code_r, .cmp_above);
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [7:0] mr(input [4:0] c);
    reg [3:0] p, n;
    integer df;
    begin
      p = c[3] ? {1'h0, c[2:0]} : {1'h0, c[2:1], c[0]};
      n = c[3] ? (c[4] ? 4'h7 : 4'h8) : {1'h0, c[2:1], ~c[0]};
      df = lv[p*8 +: 8] - lv[n*8 +: 8];
      mr = df < 0 ? 8'h00 : df[7:0];
    end
  endfunction
  // one bus access; w pulses write low, r holds read low over it
  task acc(input [4:0] c, input w, input r);
    begin
      @(posedge core_clk);
      cs_n <= 1'h0;
      d <= {3'h0, c};
      wr_n <= !w;
      rd_n <= !r;
      repeat (5) @(posedge core_clk);
      wr_n <= 1'h1;
      repeat (4) @(posedge core_clk);
      rd_n <= 1'h1;
      repeat (4) @(posedge core_clk);
      cs_n <= 1'h1;
      d <= ~d;
    end
  endtask
  task wait_done;
    begin
      for (i = 0; i < 800 && done_flag_n !== 1'h0; i++) @(posedge core_clk);
      `CHK("done", 1'h0, done_flag_n)
    end
  endtask
  always @(posedge core_clk)
  begin
    if (result_lines_oe === 8'hFF && !oe_d)
    begin
      ev = q.pop_front();
      `CHK("result", ev, result_lines_o)
    end
    oe_d <= result_lines_oe === 8'hFF;
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    repeat (4) @(posedge core_clk);
    // codes 0 to 30; each write after the first follows a read at once
    for (k = 0; k < 31; k++)
    begin
      sd = xs(sd);
      lv[31:0] = sd;
      sd = xs(sd);
      lv[63:32] = sd;
      lv[7:0] = k == 8 ? 8'hFF : lv[7:0];
      acc(k[4:0], 1, 0);
      wait_done;
      q.push_back(mr(k[4:0]));
      acc(5'h00, 0, 1);
    end
    wait_done;
    q.push_back(mr(5'h1E));
    lv = 72'h0040C0000000000011;
    acc(5'h00, 0, 1);
    wait_done;
    q.push_back(mr(5'h1E));
    acc(5'h08, 1, 1);
    wait_done;
    q.push_back(mr(5'h1E));
    acc(5'h00, 0, 1);
    results;
  end
  initial
  begin
    #3000000;
    num_errors++;
    results;
  end
  task results;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
endmodule // amcc_ctrl_tb
